// *** rtl/lsg_pkg.sv ***
package lsg_pkg;

  // ----------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------
  localparam logic [3:0] A_SEG_DATA  = 4'h0;
  localparam logic [3:0] A_SEG_DIR   = 4'h1;
  localparam logic [3:0] A_ONE_DATA  = 4'h2;
  localparam logic [3:0] A_ONE_DIR   = 4'h3;
  localparam logic [3:0] A_OUT_DATA  = 4'h4;
  localparam logic [3:0] A_OUT_MODE  = 4'h5;
  localparam logic [3:0] A_COM_DATA  = 4'h6;
  localparam logic [3:0] A_COM_DIR   = 4'h7;
  localparam logic [3:0] A_IN_DATA   = 4'h8;
  localparam logic [3:0] A_IN_MODE   = 4'h9;
  localparam logic [3:0] A_INT_EDGE  = 4'hA;

  // ----------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------
  localparam int B_PULSE_A  = 0;
  localparam int B_PULSE_B  = 1;
  localparam int B_STEPUP   = 3;
  localparam int B_EXT_INT  = 3;
  localparam int B_RISING   = 0;

  // Synchronised pin vector layout
  localparam int PIN_W      = 17;
  localparam int P_SEG_LSB  = 0;
  localparam int P_ONE      = 8;
  localparam int P_COM_LSB  = 9;
  localparam int P_IN_LSB   = 13;

  // ----------------------------------------------------------
  // Reset values and fixed read values
  // ----------------------------------------------------------
  localparam logic [5:0] OUT_DATA_RST = 6'h3F;
  localparam logic [7:0] ALL_ONES     = 8'hFF;
  localparam logic [1:0] OUT_RSV_RD   = 2'h3;
  localparam logic [3:0] NIB_RSV_RD   = 4'hF;
  localparam logic [2:0] IN_MODE_RSV  = 3'h7;

  // ----------------------------------------------------------
  // Select codes
  // ----------------------------------------------------------
  localparam logic [3:0] SEG_HI_MIN  = 4'h6;
  localparam logic [3:0] SEG_HI_MAX  = 4'hD;
  localparam logic [3:0] SEG_LO_MIN  = 4'h5;
  localparam logic [3:0] SEG_LO_MAX  = 4'hC;
  localparam logic [3:0] SEG_ONE_MIN = 4'h7;
  localparam logic [3:0] SEG_ONE_MAX = 4'hE;
  localparam logic [3:0] SEG_COM_IO  = 4'h0;
  localparam logic [3:0] ADC_CH0     = 4'h4;
  localparam logic [3:0] ADC_CH1     = 4'h5;
  localparam logic [3:0] ADC_CH2     = 4'h6;
  localparam logic [3:0] ADC_CH3     = 4'h7;

  function automatic logic in_range(
    input logic [3:0] code,
    input logic [3:0] lo,
    input logic [3:0] hi
  );
    in_range = (code >= lo) && (code <= hi);
  endfunction : in_range

endpackage : lsg_pkg

// *** rtl/lsg_pin_sync.sv ***
`timescale 1ns/100ps
module lsg_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         CLK,
  input  wire logic         RST,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ----------------------------------------------------------
  // Three stages, change taken once stages two and three agree
  // ----------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    s1 <= d;
    s2 <= s1;
    s3 <= s2;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      q <= '0;
    end
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        if (s2[i] == s3[i])
        begin
          q[i] <= s3[i];
        end
      end
    end
  end

endmodule : lsg_pin_sync

// *** rtl/lsg_gpio_ports.sv ***
`timescale 1ns/100ps
module lsg_gpio_ports
  import lsg_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic [3:0] SEGMENT_SELECT_FIELD,
  input  wire logic [3:0] ANALOG_CHANNEL_CODE,
  input  wire logic [7:0] LCD_SEGMENT_OUT,
  input  wire logic       LCD_SEGMENT_ONEBIT,
  input  wire logic [3:0] LCD_COMMON_OUT,
  input  wire logic       PULSE_A_IN,
  input  wire logic       PULSE_B_IN,
  input  wire logic [7:0] SEG_PORT_IN,
  output logic      [7:0] SEG_PORT_OUT,
  output logic      [7:0] SEG_PORT_OE,
  input  wire logic       ONEBIT_IN,
  output logic            ONEBIT_OUT,
  output logic            ONEBIT_OE,
  output logic      [5:0] OUT_PORT,
  output logic            STEPUP_ENABLE,
  input  wire logic [3:0] COM_PORT_IN,
  output logic      [3:0] COM_PORT_OUT,
  output logic      [3:0] COM_PORT_OE,
  input  wire logic [3:0] IN_PORT,
  output logic            EXT_INTERRUPT
);

  logic [7:0]       seg_data;
  logic [7:0]       seg_dir;
  logic             one_data;
  logic             one_dir;
  logic [5:0]       out_data;
  logic             pulse_a_select;
  logic             pulse_b_select;
  logic             stepup_disable;
  logic [3:0]       com_data;
  logic [3:0]       com_dir;
  logic             ext_interrupt_select;
  logic             rising_edge_sel;
  logic [PIN_W-1:0] pin_f;
  logic             irq_prev;
  logic             hi_on;
  logic             lo_on;
  logic             one_on;
  logic             com_io;
  logic [3:0]       in_read;
  logic [7:0]       next_rdata;

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  lsg_pin_sync #(
    .W (PIN_W)
  ) u_sync (
    .CLK (CLK),
    .RST (RST),
    .d   ({IN_PORT, COM_PORT_IN, ONEBIT_IN, SEG_PORT_IN}),
    .q   (pin_f)
  );

  // ----------------------------------------------------------
  // Pin function decode
  // ----------------------------------------------------------
  always_comb
  begin
    hi_on  = in_range(SEGMENT_SELECT_FIELD, SEG_HI_MIN, SEG_HI_MAX);
    lo_on  = in_range(SEGMENT_SELECT_FIELD, SEG_LO_MIN, SEG_LO_MAX);
    one_on = in_range(SEGMENT_SELECT_FIELD, SEG_ONE_MIN, SEG_ONE_MAX);
    com_io = (SEGMENT_SELECT_FIELD == SEG_COM_IO);
  end

  // Analog-selected pins read low, except pin 3 while ext_interrupt_select is set
  always_comb
  begin
    in_read = pin_f[P_IN_LSB +: 4];
    if (ANALOG_CHANNEL_CODE == ADC_CH0)
    begin
      in_read[0] = 1'b0;
    end
    if (ANALOG_CHANNEL_CODE == ADC_CH1)
    begin
      in_read[1] = 1'b0;
    end
    if (ANALOG_CHANNEL_CODE == ADC_CH2)
    begin
      in_read[2] = 1'b0;
    end
    if (ANALOG_CHANNEL_CODE == ADC_CH3 && !ext_interrupt_select)
    begin
      in_read[3] = 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Segment-shared port registers
  // ----------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      seg_data <= 8'h00;
      seg_dir  <= 8'h00;
    end
    else if (WR && ADDR == A_SEG_DATA)
    begin
      seg_data <= WDATA;
    end
    else if (WR && ADDR == A_SEG_DIR)
    begin
      seg_dir <= WDATA;
    end
  end

  // ----------------------------------------------------------
  // One-bit port registers
  // ----------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      one_data <= 1'b0;
      one_dir  <= 1'b0;
    end
    else if (WR && ADDR == A_ONE_DATA)
    begin
      one_data <= WDATA[0];
    end
    else if (WR && ADDR == A_ONE_DIR)
    begin
      one_dir <= WDATA[0];
    end
  end

  // ----------------------------------------------------------
  // Output-only port registers
  // ----------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      out_data       <= OUT_DATA_RST;
      pulse_a_select <= 1'b0;
      pulse_b_select <= 1'b0;
      stepup_disable <= 1'b0;
    end
    else if (WR && ADDR == A_OUT_DATA)
    begin
      out_data <= WDATA[5:0];
    end
    else if (WR && ADDR == A_OUT_MODE)
    begin
      pulse_a_select <= WDATA[B_PULSE_A];
      pulse_b_select <= WDATA[B_PULSE_B];
      stepup_disable <= WDATA[B_STEPUP];
    end
  end

  // ----------------------------------------------------------
  // Common-shared port registers
  // ----------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      com_data <= 4'h0;
      com_dir  <= 4'h0;
    end
    else if (WR && ADDR == A_COM_DATA)
    begin
      com_data <= WDATA[3:0];
    end
    else if (WR && ADDR == A_COM_DIR)
    begin
      com_dir <= WDATA[3:0];
    end
  end

  // ----------------------------------------------------------
  // Input-only port mode and edge choice
  // ----------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ext_interrupt_select <= 1'b0;
      rising_edge_sel      <= 1'b0;
    end
    else if (WR && ADDR == A_IN_MODE)
    begin
      ext_interrupt_select <= WDATA[B_EXT_INT];
    end
    else if (WR && ADDR == A_INT_EDGE)
    begin
      rising_edge_sel <= WDATA[B_RISING];
    end
  end

  // ----------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------
  always_comb
  begin
    next_rdata = 8'h00;
    case (ADDR)
      A_SEG_DATA:
        next_rdata = (seg_dir & seg_data)
                   | (~seg_dir & pin_f[P_SEG_LSB +: 8]);
      A_SEG_DIR:
        next_rdata = ALL_ONES;
      A_ONE_DATA:
        next_rdata = {7'h00, one_dir ? one_data : pin_f[P_ONE]};
      A_ONE_DIR:
        next_rdata = ALL_ONES;
      A_OUT_DATA:
        next_rdata = {OUT_RSV_RD, out_data};
      A_OUT_MODE:
        next_rdata = {NIB_RSV_RD, stepup_disable, 1'b0,
                      pulse_b_select, pulse_a_select};
      A_COM_DATA:
        next_rdata = {NIB_RSV_RD, (com_dir & com_data)
                     | (~com_dir & pin_f[P_COM_LSB +: 4])};
      A_COM_DIR:
        next_rdata = ALL_ONES;
      A_IN_DATA:
        next_rdata = {4'h0, in_read};
      A_IN_MODE:
        next_rdata = {NIB_RSV_RD, ext_interrupt_select,
                      IN_MODE_RSV};
      A_INT_EDGE:
        next_rdata = {7'h00, rising_edge_sel};
      default:
        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      RDATA <= 8'h00;
    end
    else
    begin
      RDATA <= RD ? next_rdata : 8'h00;
    end
  end

  // ----------------------------------------------------------
  // Pin drive, alternate function first
  // ----------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      SEG_PORT_OUT <= 8'h00;
      SEG_PORT_OE  <= 8'h00;
      ONEBIT_OUT   <= 1'b0;
      ONEBIT_OE    <= 1'b0;
    end
    else
    begin
      SEG_PORT_OUT[7:4] <= hi_on ? LCD_SEGMENT_OUT[7:4] : seg_data[7:4];
      SEG_PORT_OE[7:4]  <= hi_on ? 4'hF : seg_dir[7:4];
      SEG_PORT_OUT[3:0] <= lo_on ? LCD_SEGMENT_OUT[3:0] : seg_data[3:0];
      SEG_PORT_OE[3:0]  <= lo_on ? 4'hF : seg_dir[3:0];
      ONEBIT_OUT        <= one_on ? LCD_SEGMENT_ONEBIT : one_data;
      ONEBIT_OE         <= one_on | one_dir;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      COM_PORT_OUT <= 4'h0;
      COM_PORT_OE  <= 4'h0;
    end
    else
    begin
      COM_PORT_OUT <= com_io ? com_data : LCD_COMMON_OUT;
      COM_PORT_OE  <= com_io ? com_dir : 4'hF;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      OUT_PORT      <= OUT_DATA_RST;
      STEPUP_ENABLE <= 1'b0;
    end
    else
    begin
      OUT_PORT[5:2] <= out_data[5:2];
      OUT_PORT[0]   <= pulse_a_select ? PULSE_A_IN : out_data[0];
      OUT_PORT[1]   <= pulse_b_select ? PULSE_B_IN : out_data[1];
      STEPUP_ENABLE <= !stepup_disable;
    end
  end

  // ----------------------------------------------------------
  // External interrupt edge detect
  // ----------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      irq_prev      <= 1'b0;
      EXT_INTERRUPT <= 1'b0;
    end
    else
    begin
      irq_prev      <= pin_f[P_IN_LSB + 3];
      EXT_INTERRUPT <= ext_interrupt_select
                     && (pin_f[P_IN_LSB + 3] != irq_prev)
                     && (pin_f[P_IN_LSB + 3] == rising_edge_sel);
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_seg_rd;
    RD && ADDR == A_SEG_DATA;
  endsequence

  sequence s_in_rd_ch2;
    RD && ADDR == A_IN_DATA && ANALOG_CHANNEL_CODE == ADC_CH2;
  endsequence

  sequence s_irq_rise;
    ext_interrupt_select && rising_edge_sel
      && !irq_prev && pin_f[P_IN_LSB + 3];
  endsequence

  property p_seg_hi;
    hi_on |=> SEG_PORT_OE[7:4] == 4'hF
          && SEG_PORT_OUT[7:4] == $past(LCD_SEGMENT_OUT[7:4]);
  endproperty
  a_seg_hi: assert property (p_seg_hi) else $error("upper nibble not segment");

  property p_seg_lo;
    !lo_on |=> SEG_PORT_OE[3:0] == $past(seg_dir[3:0])
           && SEG_PORT_OUT[3:0] == $past(seg_data[3:0]);
  endproperty
  a_seg_lo: assert property (p_seg_lo) else $error("lower nibble not gpio");

  property p_one;
    one_on |=> ONEBIT_OE && ONEBIT_OUT == $past(LCD_SEGMENT_ONEBIT);
  endproperty
  a_one: assert property (p_one) else $error("one-bit pin not segment");

  property p_seg_read;
    s_seg_rd ##0 (seg_dir == 8'h00) |=> RDATA == $past(pin_f[7:0]);
  endproperty
  a_seg_read: assert property (p_seg_read) else $error("input read not pin");

  property p_dir_read;
    RD && (ADDR == A_SEG_DIR || ADDR == A_COM_DIR) |=> RDATA == 8'hFF;
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction read not ones");

  property p_out_reset;
    $fell(RST) |-> OUT_PORT == 6'h3F && !stepup_disable ##1 STEPUP_ENABLE;
  endproperty
  a_out_reset: assert property (p_out_reset) else $error("output port reset bad");

  property p_pulse;
    pulse_a_select |=> OUT_PORT[0] == $past(PULSE_A_IN);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse a not routed");

  property p_com;
    SEGMENT_SELECT_FIELD != 4'h0 |=> COM_PORT_OE == 4'hF
      && COM_PORT_OUT == $past(LCD_COMMON_OUT);
  endproperty
  a_com: assert property (p_com) else $error("common pins not lcd");

  property p_analog;
    s_in_rd_ch2 |=> !RDATA[2];
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin read high");

  property p_mode_rsv;
    RD && ADDR == A_IN_MODE |=> RDATA[7:4] == 4'hF && RDATA[2:0] == 3'h7;
  endproperty
  a_mode_rsv: assert property (p_mode_rsv) else $error("mode reserved bits bad");

  property p_irq;
    s_irq_rise |=> EXT_INTERRUPT;
  endproperty
  a_irq: assert property (p_irq) else $error("rising edge missed");

endmodule : lsg_gpio_ports

// *** verification/lsg_board.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------
// Board side of the shared pins
// ----------------------------------------------------------
module lsg_board (
  input  wire logic [7:0] seg_out,
  input  wire logic [7:0] seg_oe,
  input  wire logic       one_out,
  input  wire logic       one_oe,
  input  wire logic [3:0] com_out,
  input  wire logic [3:0] com_oe,
  input  wire logic [7:0] seg_ext,
  input  wire logic       one_ext,
  input  wire logic [3:0] com_ext,
  output logic      [7:0] seg_pin,
  output logic            one_pin,
  output logic      [3:0] com_pin
);
  // Device drive wins, else board level
  assign seg_pin = (seg_oe & seg_out) | (~seg_oe & seg_ext);
  assign one_pin = one_oe ? one_out : one_ext;
  assign com_pin = (com_oe & com_out) | (~com_oe & com_ext);
endmodule : lsg_board

// *** verification/tb.sv ***
`timescale 1ns/100ps
module tb;
  import lsg_pkg::*;
  logic        clk, rst, wr, rd, lcd_one, pwm_a, pwm_b, one_ext;
  logic        one_in, one_out, one_oe, stepup, ext_int;
  logic [3:0]  addr, sel, chan, lcd_com, com_ext, com_in, com_out, com_oe, in_port, mk;
  logic [7:0]  wdata, rdata, lcd_seg, seg_ext, seg_in, seg_out, seg_oe, d, m;
  logic [5:0]  out_port;
  logic [12:0] ow, eo, ex, d13, m13, p13;
  int          seed, n_errors, checked, cyc, n_irq, i;

  lsg_gpio_ports lsg_gpio_ports_i (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .SEGMENT_SELECT_FIELD(sel), .ANALOG_CHANNEL_CODE(chan), .LCD_SEGMENT_OUT(lcd_seg),
    .LCD_SEGMENT_ONEBIT(lcd_one), .LCD_COMMON_OUT(lcd_com), .PULSE_A_IN(pwm_a),
    .PULSE_B_IN(pwm_b), .SEG_PORT_IN(seg_in), .SEG_PORT_OUT(seg_out), .SEG_PORT_OE(seg_oe),
    .ONEBIT_IN(one_in), .ONEBIT_OUT(one_out), .ONEBIT_OE(one_oe), .OUT_PORT(out_port),
    .STEPUP_ENABLE(stepup), .COM_PORT_IN(com_in), .COM_PORT_OUT(com_out),
    .COM_PORT_OE(com_oe), .IN_PORT(in_port), .EXT_INTERRUPT(ext_int));

  lsg_board lsg_board_i (
    .seg_out(seg_out), .seg_oe(seg_oe), .one_out(one_out), .one_oe(one_oe),
    .com_out(com_out), .com_oe(com_oe), .seg_ext(seg_ext), .one_ext(one_ext),
    .com_ext(com_ext), .seg_pin(seg_in), .one_pin(one_in), .com_pin(com_in));

  // ----------------------------------------------------------
  // Clock, timeout, pulse counter
  // ----------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (ext_int === 1'b1) n_irq++;
    cyc++;
    if (cyc == 6000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------
  // Tasks and functions
  // ----------------------------------------------------------
  function automatic logic [12:0] own(input logic [3:0] c);
    own = {{4{c != 4'h0}}, (c >= 4'h7 && c <= 4'hE), {4{c >= 4'h6 && c <= 4'hD}},
           {4{c >= 4'h5 && c <= 4'hC}}};
  endfunction : own

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic chk_reg(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] g;
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    g = rdata;
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED reg %h exp %h got %h", a, e, g);
    end
  endtask : chk_reg

  task automatic chk_pin(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk_pin

  task automatic irq_step(input logic [3:0] v, input int e);
    int c0;
    @(negedge clk);
    c0 = n_irq;
    @(posedge clk);
    in_port <= v;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk_pin("ext_int", 16'(e), 16'(n_irq - c0));
  endtask : irq_step

  task automatic end_of_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial
  begin
    seed = 86;
    rst = 1'b1;
    {wr, rd, addr, wdata, sel, chan, lcd_seg, lcd_one, lcd_com} = '0;
    {pwm_a, pwm_b, seg_ext, one_ext, com_ext, in_port} = '0;
    {n_errors, checked, cyc, n_irq} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_pin("out_port", 16'(OUT_DATA_RST), 16'(out_port));
    chk_pin("stepup", 16'h0001, 16'(stepup));
    chk_pin("oe", 16'h0000, 16'({com_oe, one_oe, seg_oe}));
    chk_reg(A_OUT_DATA, {OUT_RSV_RD, OUT_DATA_RST});
    chk_reg(A_OUT_MODE, 8'hF0);
    chk_reg(A_SEG_DIR, ALL_ONES);
    chk_reg(A_ONE_DIR, ALL_ONES);
    chk_reg(A_COM_DIR, ALL_ONES);
    chk_reg(A_IN_MODE, 8'hF7);
    wr_reg(A_IN_MODE, 8'h00);
    chk_reg(A_IN_MODE, 8'hF7);
    chk_reg(4'hC, 8'h00);
    chk_reg(A_SEG_DATA, 8'h00);
    // Every select code with random data, direction and board levels
    for (i = 0; i < 16; i++)
    begin
      d = 8'($random(seed));
      m = 8'($random(seed));
      wr_reg(A_SEG_DATA, d);
      wr_reg(A_SEG_DIR, m);
      wr_reg(A_ONE_DATA, {7'h00, d[0]});
      wr_reg(A_ONE_DIR, {7'h00, m[0]});
      wr_reg(A_COM_DATA, {4'hF, d[7:4]});
      wr_reg(A_COM_DIR, {4'hF, m[7:4]});
      @(posedge clk);
      sel <= i[3:0];
      lcd_seg <= 8'($random(seed));
      lcd_com <= 4'($random(seed));
      lcd_one <= 1'($random(seed));
      seg_ext <= 8'($random(seed));
      com_ext <= 4'($random(seed));
      one_ext <= 1'($random(seed));
      repeat (2) @(posedge clk);
      @(negedge clk);
      ow = own(sel);
      m13 = {m[7:4], m[0], m};
      d13 = {d[7:4], d[0], d};
      eo = ow | m13;
      ex = (ow & {lcd_com, lcd_one, lcd_seg}) | (~ow & d13);
      chk_pin("oe", 16'(eo), 16'({com_oe, one_oe, seg_oe}));
      chk_pin("out", 16'(ex & eo), 16'({com_out, one_out, seg_out} & eo));
      p13 = (eo & ex) | (~eo & {com_ext, one_ext, seg_ext});
      p13 = (m13 & d13) | (~m13 & p13);
      repeat (6) @(posedge clk);
      chk_reg(A_SEG_DATA, p13[7:0]);
      chk_reg(A_ONE_DATA, {7'h00, p13[8]});
      chk_reg(A_COM_DATA, {4'hF, p13[12:9]});
    end
    // Output-only port in all four pulse modes
    for (i = 0; i < 4; i++)
    begin
      d = 8'($random(seed));
      wr_reg(A_OUT_DATA, {2'b11, d[5:0]});
      wr_reg(A_OUT_MODE, {6'h3C, i[1:0]});
      @(posedge clk);
      pwm_a <= 1'($random(seed));
      pwm_b <= 1'($random(seed));
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk_pin("out_port", 16'({d[5:2], i[1] ? pwm_b : d[1], i[0] ? pwm_a : d[0]}),
              16'(out_port));
      chk_reg(A_OUT_DATA, {2'b11, d[5:0]});
      chk_reg(A_OUT_MODE, {6'h3C, i[1:0]});
    end
    // Step-up toggled only with large-current pins high
    wr_reg(A_OUT_DATA, 8'hFF);
    wr_reg(A_OUT_MODE, 8'hF8);
    @(posedge clk);
    @(negedge clk);
    chk_pin("stepup", 16'h0000, 16'(stepup));
    wr_reg(A_OUT_MODE, 8'hF0);
    @(posedge clk);
    @(negedge clk);
    chk_pin("stepup", 16'h0001, 16'(stepup));
    repeat (30) @(posedge clk);
    wr_reg(A_OUT_DATA, 8'hF8);
    @(posedge clk);
    @(negedge clk);
    chk_pin("out_port", 16'h0038, 16'(out_port));
    // Input-only port against every channel code
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk);
      chan <= i[3:0];
      in_port <= 4'($random(seed));
      repeat (6) @(posedge clk);
      mk = (chan >= 4'h4 && chan <= 4'h7) ? 4'(1 << (chan - 4'h4)) : 4'h0;
      chk_reg(A_IN_DATA, {4'h0, in_port & ~mk});
    end
    // External interrupt edges and pin sharing
    @(posedge clk);
    chan <= ADC_CH3;
    in_port <= 4'h0;
    wr_reg(A_INT_EDGE, 8'h01);
    wr_reg(A_IN_MODE, 8'h08);
    irq_step(4'h8, 1);
    chk_reg(A_IN_DATA, 8'h08);
    irq_step(4'h0, 0);
    wr_reg(A_INT_EDGE, 8'h00);
    irq_step(4'h8, 0);
    irq_step(4'h0, 1);
    wr_reg(A_IN_MODE, 8'h00);
    irq_step(4'h8, 0);
    irq_step(4'h0, 0);
    end_of_test();
  end
endmodule : tb
